// *** mpp_defines.vh ***
`ifndef MPP_DEFINES_VH
`define MPP_DEFINES_VH
// Register word offsets (byte addresses on the Wishbone bus)
`define MPP_OFS_INT_LO 5'h00
`define MPP_OFS_INT_HI 5'h04
`define MPP_OFS_LVL_LO 5'h08
`define MPP_OFS_LVL_HI 5'h0C
`define MPP_OFS_TRI_LO 5'h10
`define MPP_OFS_TRI_HI 5'h14
`define MPP_OFS_INV_LO 5'h18
`define MPP_OFS_INV_HI 5'h1C
`define MPP_OFS_SEL_LO 5'h00
`define MPP_OFS_SEL_HI 5'h04
`define MPP_OFS_OD_LO 5'h08
`define MPP_OFS_OD_HI 5'h0C
`define MPP_OFS_CTL 5'h10
// Address bit choosing the upper bank of the map
`define MPP_BANK_BIT 5
// Reset values of one 8-bit register
`define MPP_RST_ZERO 8'h00
`define MPP_RST_SEL 8'hFF
// Control register fields
`define MPP_CTL_TIMER_ROUTE 0
`define MPP_CTL_INT_PEND 1
`endif

// *** mpp_pin_cell.v ***
`timescale 1ns/1ns
`default_nettype none
// One pin: input synchroniser, inversion, edge sense and output driver
module mpp_pin_cell
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Per-pin settings
  input wire dir_in,
  input wire level,
  input wire tristate,
  input wire invert,
  input wire open_drain,
  input wire int_en,
  // Timer takeover
  input wire timer_route,
  input wire timer_level,
  // Pad
  input wire pad_in,
  output reg pad_out,
  output reg pad_oe,
  // Status
  output wire pin_state,
  output wire edge_hit
);
  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;
  wire eff_in;
  wire sense_in;

  // Two-stage synchroniser for the pad; first stage read only by second
  // Resets to the pulled-up idle level, so no false edge follows reset
  always @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sense_in;
    end
  end

  // Inverted view of the pin when invert is set
  assign eff_in = invert ? ~sync2_reg : sync2_reg;
  assign pin_state = eff_in;
  // Level bit picks active sense on top of inversion
  assign sense_in = level ? ~eff_in : eff_in;
  // Edge only counts on an enabled input not owned by the timer
  assign edge_hit = int_en & dir_in & ~timer_route &
                    sense_in & ~prev_reg;

  // Registered pad driver
  always @(posedge clk)
  begin
    if (rst)
    begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end
    else if (timer_route)
    begin
      pad_out <= timer_level;
      pad_oe <= 1'b1;
    end
    else if (dir_in)
    begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end
    else if (tristate)
    begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end
    else if (open_drain)
    begin
      pad_out <= 1'b0;
      pad_oe <= ~level;
    end
    else
    begin
      pad_out <= level;
      pad_oe <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** mpp_port.v ***
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "mpp_defines.vh"
module mpp_port #
(
  parameter PINS = 16
)
(
  // System
  input wire clk,
  input wire rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // Timer output from the counter block
  input wire timer_out,
  // Pins
  input wire [PINS-1:0] pin_in,
  output wire [PINS-1:0] pin_out,
  output wire [PINS-1:0] pin_oe,
  // Interrupt request toward UART channel 0 status
  output reg pin_irq
);
  reg [PINS-1:0] int_en_reg;
  reg [PINS-1:0] level_reg;
  reg [PINS-1:0] tri_reg;
  reg [PINS-1:0] inv_reg;
  reg [PINS-1:0] sel_reg;
  reg [PINS-1:0] od_reg;
  reg [PINS-1:0] pend_reg;
  reg [PINS-1:0] pend_next;
  reg route_reg;
  reg timer_sync1_reg;
  reg timer_sync2_reg;
  reg [31:0] rd_next;
  reg hit_next;
  wire [PINS-1:0] state;
  wire [PINS-1:0] edges;
  wire req;
  wire wr;
  wire rd;
  wire bank;
  wire [4:0] ofs;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign bank = wb_adr_i[`MPP_BANK_BIT];
  assign ofs = wb_adr_i[4:0];

  // Timer level comes from another block's pin path; synchronise it
  always @(posedge clk)
  begin
    if (rst)
    begin
      timer_sync1_reg <= 1'b1;
      timer_sync2_reg <= 1'b1;
    end
    else
    begin
      timer_sync1_reg <= timer_out;
      timer_sync2_reg <= timer_sync1_reg;
    end
  end

  // One cell per pin; pin 0 alone can be taken by the timer
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1)
    begin : g_pin
      mpp_pin_cell u_cell
      (
        .clk(clk),
        .rst(rst),
        .dir_in(sel_reg[i]),
        .level(level_reg[i]),
        .tristate(tri_reg[i]),
        .invert(inv_reg[i]),
        .open_drain(od_reg[i]),
        .int_en(int_en_reg[i]),
        .timer_route((i == 0) ? route_reg : 1'b0),
        .timer_level(timer_sync2_reg),
        .pad_in(pin_in[i]),
        .pad_out(pin_out[i]),
        .pad_oe(pin_oe[i]),
        .pin_state(state[i]),
        .edge_hit(edges[i])
      );
    end
  endgenerate

  // Read mux and address decode; unmapped words answer with err
  always @*
  begin
    rd_next = 32'h00000000;
    hit_next = 1'b1;
    if (!bank)
    begin
      case (ofs)
        `MPP_OFS_INT_LO: rd_next[7:0] = int_en_reg[7:0];
        `MPP_OFS_INT_HI: rd_next[7:0] = int_en_reg[15:8];
        `MPP_OFS_LVL_LO: rd_next[7:0] = state[7:0];
        `MPP_OFS_LVL_HI: rd_next[7:0] = state[15:8];
        `MPP_OFS_TRI_LO: rd_next[7:0] = tri_reg[7:0];
        `MPP_OFS_TRI_HI: rd_next[7:0] = tri_reg[15:8];
        `MPP_OFS_INV_LO: rd_next[7:0] = inv_reg[7:0];
        `MPP_OFS_INV_HI: rd_next[7:0] = inv_reg[15:8];
        default: hit_next = 1'b0;
      endcase
    end
    else
    begin
      case (ofs)
        `MPP_OFS_SEL_LO: rd_next[7:0] = sel_reg[7:0];
        `MPP_OFS_SEL_HI: rd_next[7:0] = sel_reg[15:8];
        `MPP_OFS_OD_LO: rd_next[7:0] = od_reg[7:0];
        `MPP_OFS_OD_HI: rd_next[7:0] = od_reg[15:8];
        `MPP_OFS_CTL:
        begin
          rd_next[`MPP_CTL_TIMER_ROUTE] = route_reg;
          rd_next[`MPP_CTL_INT_PEND] = |pend_reg;
        end
        default: hit_next = 1'b0;
      endcase
    end
  end

  // Pending edges; a level read clears, but a new edge wins
  always @*
  begin
    pend_next = pend_reg;
    if (rd && hit_next && !bank &&
        (ofs == `MPP_OFS_LVL_LO || ofs == `MPP_OFS_LVL_HI))
      pend_next = {PINS{1'b0}};
    pend_next = pend_next | edges;
  end

  // Bus answer in the cycle after the request is seen
  always @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      pend_reg <= {PINS{1'b0}};
      pin_irq <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req & hit_next;
      wb_err_o <= req & ~hit_next;
      wb_dat_o <= rd ? rd_next : 32'h00000000;
      pend_reg <= pend_next;
      pin_irq <= |pend_next;
    end
  end

  // Control registers; only byte lane 0 carries data
  always @(posedge clk)
  begin
    if (rst)
    begin
      int_en_reg <= {2{`MPP_RST_ZERO}};
      level_reg <= {2{`MPP_RST_ZERO}};
      tri_reg <= {2{`MPP_RST_ZERO}};
      inv_reg <= {2{`MPP_RST_ZERO}};
      sel_reg <= {2{`MPP_RST_SEL}};
      od_reg <= {2{`MPP_RST_ZERO}};
      route_reg <= 1'b0;
    end
    else if (wr && !bank)
    begin
      case (ofs)
        `MPP_OFS_INT_LO: int_en_reg[7:0] <= wb_dat_i[7:0];
        `MPP_OFS_INT_HI: int_en_reg[15:8] <= wb_dat_i[7:0];
        `MPP_OFS_LVL_LO: level_reg[7:0] <= wb_dat_i[7:0];
        `MPP_OFS_LVL_HI: level_reg[15:8] <= wb_dat_i[7:0];
        `MPP_OFS_TRI_LO: tri_reg[7:0] <= wb_dat_i[7:0];
        `MPP_OFS_TRI_HI: tri_reg[15:8] <= wb_dat_i[7:0];
        `MPP_OFS_INV_LO: inv_reg[7:0] <= wb_dat_i[7:0];
        `MPP_OFS_INV_HI: inv_reg[15:8] <= wb_dat_i[7:0];
        default: int_en_reg <= int_en_reg;
      endcase
    end
    else if (wr && bank)
    begin
      case (ofs)
        `MPP_OFS_SEL_LO: sel_reg[7:0] <= wb_dat_i[7:0];
        `MPP_OFS_SEL_HI: sel_reg[15:8] <= wb_dat_i[7:0];
        `MPP_OFS_OD_LO: od_reg[7:0] <= wb_dat_i[7:0];
        `MPP_OFS_OD_HI: od_reg[15:8] <= wb_dat_i[7:0];
        `MPP_OFS_CTL: route_reg <= wb_dat_i[`MPP_CTL_TIMER_ROUTE];
        default: sel_reg <= sel_reg;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** mpp_port_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
// Bus and pad checks on the pin block
module mpp_chk #(parameter PINS = 16)
(
  // System
  input wire clk,
  input wire rst,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  // Pads
  input wire [PINS-1:0] pin_in,
  input wire [PINS-1:0] pin_oe,
  input wire pin_irq
);
  logic [3:0] calm_reg;
  logic [PINS-1:0] last_reg;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire lvl_rd = wb_ack_o && !wb_we_i && wb_adr_i[5:3] == 3'h1;
  // Quiet pads only, so a fresh edge cannot re-arm a cleared request
  always @(posedge clk)
  begin
    last_reg <= pin_in;
    if (rst)
      calm_reg <= 4'h0;
    else
      calm_reg <= (pin_in != last_reg) ? 4'h0 :
        calm_reg + {3'h0, calm_reg != 4'hF};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr;
    wb_ack_o && wb_we_i;
  endsequence
  sequence s_rd;
    lvl_rd && calm_reg > 4'h8;
  endsequence
  property p_ok;
    take && wb_adr_i[5:2] <= 4'hC |=> wb_ack_o && !wb_err_o;
  endproperty
  property p_err;
    take && wb_adr_i[5:2] > 4'hC |=> wb_err_o && !wb_ack_o;
  endproperty
  property p_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_hi;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  property p_rst;
    $fell(rst) |-> pin_oe == '0 ##1 pin_oe == '0;
  endproperty
  property p_upd;
    !$stable(pin_oe[PINS-1:1]) |-> $past(wb_ack_o && wb_we_i) ||
      $past(wb_ack_o && wb_we_i, 2);
  endproperty
  property p_hold;
    pin_irq && !wb_cyc_i && !$past(wb_cyc_i) |=> pin_irq;
  endproperty
  property p_clr;
    s_rd |-> ##[1:3] !pin_irq;
  endproperty
  a_ok: assert property (p_ok) else $error("no ack");
  a_err: assert property (p_err) else $error("no err");
  a_pulse: assert property (p_pulse) else $error("long ack");
  a_hi: assert property (p_hi) else $error("upper bits");
  a_rst: assert property (p_rst) else $error("oe after reset");
  a_upd: assert property (p_upd) else $error("stray oe");
  a_hold: assert property (p_hold) else $error("irq lost");
  a_clr: assert property (p_clr) else $error("irq kept");
endmodule
`default_nettype wire

// *** mpp_pads.sv ***
`timescale 1ns/1ns
`default_nettype none
// Board side: pull-ups plus an outside driver
module mpp_pads
(
  // From the block
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  // Outside driver
  input wire logic [15:0] ext_val,
  input wire logic [15:0] ext_en,
  // To the block
  output wire logic [15:0] pin_in
);
  // Block wins where it drives; idle lines float high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_en) |
    (~pin_oe & ext_en & ext_val);
endmodule
`default_nettype wire

// *** mpp_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tmr = 1'b1;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, err, irq;
  logic [15:0] pout, poe, pin, ev = 16'h0, ee = 16'h0;
  logic [32:0] q[$];
  logic [32:0] x;
  logic [7:0] r;
  int seed = 32'hA675;
  int miscompares = 0, n_compared = 0;
  mpp_port u_mpp_port (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .timer_out(tmr), .pin_in(pin), .pin_out(pout), .pin_oe(poe),
    .pin_irq(irq));
  mpp_pads u_mpp_pads (.pin_out(pout), .pin_oe(poe), .ext_val(ev),
    .ext_en(ee), .pin_in(pin));
  // 25 MHz
  initial forever #20 clk = ~clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task final_report;
    $display("%0d mismatches in %0d checks", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Classic cycle, held until the answer edge
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1 && ++n < 20);
    // A slave that never answers counts as a mismatch
    if (ack !== 1'b1 && err !== 1'b1)
      miscompares++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  // Note bit 8 means an error answer is due
  task rd(input logic [5:0] a, input logic [8:0] e);
    q.push_back({e[8], 24'h0, e[7:0]});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask
  // Output stage is one cycle behind the write
  task pads(input logic [15:0] oe, input logic [15:0] o);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({16'h0, poe}, {16'h0, oe});
    chk({16'h0, pout}, {16'h0, o});
  endtask
  // Oldest note against each read answer
  always @(posedge clk)
    if ((ack === 1'b1 || err === 1'b1) && we === 1'b0 && q.size() > 0)
    begin
      x = q.pop_front();
      chk({31'h0, err}, {31'h0, x[32]});
      if (!x[32])
        chk(rdat, x[31:0]);
    end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++)
      rd(6'(i * 4), (i % 6 == 2 || i % 6 == 3) ? 9'h0FF : 9'h000);
    rd(6'h34, 9'h100);
    pads(16'h0000, 16'h0000);
    $display("reset test done");
    r = 8'($random(seed));
    wr(6'h20, 8'h00);
    wr(6'h08, r);
    pads(16'h00FF, {8'h00, r});
    rd(6'h08, {1'b0, r});
    wr(6'h10, 8'h0F);
    pads(16'h00F0, {8'h00, r & 8'hF0});
    wr(6'h10, 8'h00);
    wr(6'h28, 8'hFF);
    pads({8'h00, ~r}, 16'h0000);
    bus(1'b1, 6'h24, 8'h00, 4'hE);
    rd(6'h24, 9'h0FF);
    r = 8'($random(seed));
    ev <= {r, 8'h00};
    ee <= 16'hFF00;
    wr(6'h1C, 8'hF0);
    rd(6'h0C, {1'b0, r ^ 8'hF0});
    $display("output and input test done");
    ev <= 16'h0100;
    wr(6'h1C, 8'h00);
    wr(6'h00, 8'h01);
    wr(6'h04, 8'h01);
    repeat (8) @(posedge clk);
    rd(6'h0C, 9'h001);
    ev <= 16'h0000;
    wr(6'h08, 8'h00);
    wr(6'h08, 8'hFF);
    repeat (8) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    ev <= 16'h0100;
    repeat (8) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(6'h0C, 9'h001);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("interrupt test done");
    wr(6'h30, 8'h01);
    pads(16'h0001, 16'h0001);
    tmr <= 1'b0;
    repeat (3) @(posedge clk);
    pads(16'h0001, 16'h0000);
    wr(6'h30, 8'h00);
    pads(16'h0000, 16'h0000);
    $display("timer test done");
    final_report;
  end
  // Hang guard
  initial
  begin
    repeat (4000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule
bind mpp_port mpp_chk #(.PINS(PINS)) u_mpp_chk (.*);
`default_nettype wire
